// >>> rtl/mq_defines.svh
`ifndef MQ_DEFINES_SVH
`define MQ_DEFINES_SVH

// sizes of the queue array and its buses
`define MQ_QUEUES    16
`define MQ_QIDX_W    4
`define MQ_DATA_W    18
`define MQ_QDEPTH    16
`define MQ_WADDR_W   7
`define MQ_RADDR_W   8
`define MQ_ID_W      3
// field positions inside the address buses
`define MQ_QIDX_HI   3
`define MQ_NULL_BIT  4
`define MQ_WID_LO    4
`define MQ_WID_HI    6
`define MQ_RID_LO    5
`define MQ_RID_HI    7
// reset values
`define MQ_QIDX_RST  4'h0
`define MQ_RSRC_RST  5'h10

`endif

// >>> rtl/mq_pkg.sv
`include "mq_defines.svh"

package mq_pkg;

  // selection sequence after an address strobe
  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_FIRST  = 2'b01,
    PH_SECOND = 2'b10
  } sel_phase_type;

  // write port request group
  typedef struct packed {
    logic                     write_address_enable;
    logic [`MQ_WADDR_W-1:0]   write_queue_address;
    logic                     write_enable_n;
    logic [`MQ_DATA_W-1:0]    write_data;
  } wr_port_type;

  // read port request group
  typedef struct packed {
    logic                     read_address_enable;
    logic [`MQ_RADDR_W-1:0]   read_queue_address;
    logic                     read_enable_n;
  } rd_port_type;

  // one pipeline stage: word plus its validity
  typedef struct packed {
    logic                     valid;
    logic [`MQ_DATA_W-1:0]    data;
  } stage_type;

  // read source: null flag on top, queue index below
  typedef struct packed {
    logic                     null_q;
    logic [`MQ_QIDX_W-1:0]    idx;
  } rsrc_type;

endpackage

// >>> rtl/multi_queue_port_select.sv
`timescale 1ns/1ps
`include "mq_defines.svh"
// Behaviour
// [R01] write address taken while address enable high
// [R02] selection persists until next selection
// [R03] write data accepted on every edge
// [R04] controller spaces write selections two cycles
// [R05] full flag follows new queue next edge
// [R06] new queue written from second edge
// [R07] two transition cycles write previous queue
// [R08] full queue never written
// [R09] write address: queue index plus identity
// [R10] read address taken while address enable high
// [R11] controller spaces read selections two cycles
// [R12] new queue word reaches output after two
// [R13] previous queue read on switch edges
// [R14] two stage pipeline carries old, new
// [R15] output enable only gates data pins
// [R16] empty selection leaves last word, invalid
// [R17] read address: queue, null bit, identity
// [R18] null bit selects null queue
// [R19] null queue acts permanently empty
// [R20] null queue only on read port
// [R21] last word drains to output itself
// [R22] valid flag describes output register word
// [R23] full flag reports write-selected queue only
// [R24] full previous queue blocks transition writes

// one queue: flip-flop ring with valid/ready on both sides
module queue_fifo #(
  parameter int WIDTH = `MQ_DATA_W,
  parameter int DEPTH = `MQ_QDEPTH
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];      // storage words
  logic [AW:0]      wp;               // write pointer, wrap bit on top
  logic [AW:0]      rp;               // read pointer, wrap bit on top
  logic [AW:0]      next_wp;
  logic [AW:0]      next_rp;
  logic             push;
  logic             pop;

  // full when pointers differ only in the wrap bit
  always_comb begin
    in_ready  = !((wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]));
    out_valid = (wp != rp);
    out_data  = mem[rp[AW-1:0]];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    next_wp   = push ? wp + 1'b1 : wp;
    next_rp   = pop ? rp + 1'b1 : rp;
  end

  // pointers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wp <= '0;
      rp <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
    end
  end

  // storage, written at the write pointer
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wp[AW-1:0]] <= in_data;
    end
  end
endmodule // queue_fifo

module multi_queue_port_select (
  // clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  // static identity straps
  input  wire logic                    device_identity_bit0,
  input  wire logic                    device_identity_bit1,
  input  wire logic                    device_identity_bit2,
  // write port
  input  wire mq_pkg::wr_port_type     wr_port,
  output logic                         queue_full_n,
  output logic                         queue_full_oe_n,
  // read port
  input  wire mq_pkg::rd_port_type     rd_port,
  input  wire logic                    output_enable_n,
  output logic [`MQ_DATA_W-1:0]        read_data,
  output logic                         read_data_oe_n,
  output logic                         output_valid_n
);

  // compare the top address bits with the straps
  function automatic logic id_match(input logic [`MQ_ID_W-1:0] a, input logic [`MQ_ID_W-1:0] id);
    id_match = (a == id);
  endfunction

  logic [`MQ_ID_W-1:0]    dev_id;                 // strap bits as a code
  logic [`MQ_QUEUES-1:0]  q_full;                 // per queue full status
  logic [`MQ_QUEUES-1:0]  q_ne;                   // per queue not empty
  logic [`MQ_QUEUES-1:0]  wr_fire;                // per queue write strobe
  logic [`MQ_QUEUES-1:0]  rd_pop;                 // per queue read strobe
  logic [`MQ_DATA_W-1:0]  q_data [`MQ_QUEUES];    // head word of each queue

  assign dev_id = {device_identity_bit2, device_identity_bit1, device_identity_bit0};

  // ---------------- write selection ----------------
  mq_pkg::sel_phase_type  wph;                    // write switch phase
  mq_pkg::sel_phase_type  next_wph;
  logic [`MQ_QIDX_W-1:0]  wq;                     // queue taking writes
  logic [`MQ_QIDX_W-1:0]  next_wq;
  logic                   wdev;                   // this device selected
  logic                   next_wdev;
  logic [`MQ_QIDX_W-1:0]  wnew;                   // pending new queue
  logic [`MQ_QIDX_W-1:0]  next_wnew;
  logic                   wnew_dev;               // pending device match
  logic                   next_wnew_dev;
  logic                   w_id_ok;

  // selection capture and delayed switch of the write target
  always_comb begin
    w_id_ok       = id_match(wr_port.write_queue_address[`MQ_WID_HI:`MQ_WID_LO], dev_id); // see [R09]
    next_wph      = wph;
    next_wq       = wq;
    next_wdev     = wdev;
    next_wnew     = wnew;
    next_wnew_dev = wnew_dev;
    if (wr_port.write_address_enable) begin
      // take the address, enable of write ignored for selection
      next_wnew     = wr_port.write_queue_address[`MQ_QIDX_HI:0]; // see [R01]
      next_wnew_dev = w_id_ok;
      next_wph      = mq_pkg::PH_FIRST;
    end else begin
      case (wph)
        mq_pkg::PH_FIRST: begin
          // next edge after selection: writes and flag move over
          next_wq   = wnew; // see [R05]
          next_wdev = wnew_dev;
          next_wph  = mq_pkg::PH_IDLE;
        end
        mq_pkg::PH_IDLE: begin
          next_wph = mq_pkg::PH_IDLE; // see [R02]
        end
        default: begin
          next_wph = mq_pkg::PH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wph      <= mq_pkg::PH_IDLE;
      wq       <= `MQ_QIDX_RST;
      wdev     <= 1'b0;
      wnew     <= `MQ_QIDX_RST;
      wnew_dev <= 1'b0;
    end else begin
      wph      <= next_wph;
      wq       <= next_wq;
      wdev     <= next_wdev;
      wnew     <= next_wnew;
      wnew_dev <= next_wnew_dev;
    end
  end

  // write strobe: every edge, to the current target, never into a full queue
  always_comb begin
    for (int i = 0; i < `MQ_QUEUES; i++) begin
      wr_fire[i] = !wr_port.write_enable_n && wdev && (wq == i[`MQ_QIDX_W-1:0])
                   && !q_full[i]; // see [R03] see [R06] see [R07] see [R08] see [R24]
    end
  end

  // flag of the write-selected queue; released when another device owns the bus
  assign queue_full_n    = !q_full[wq]; // see [R23]
  assign queue_full_oe_n = !wdev;

  // ---------------- queue storage ----------------
  for (genvar g = 0; g < `MQ_QUEUES; g++) begin : g_queue
    queue_fifo #(
      .WIDTH (`MQ_DATA_W),
      .DEPTH (`MQ_QDEPTH)
    ) u_fifo (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .in_valid  (wr_fire[g]),
      .in_ready  (),
      .in_data   (wr_port.write_data),
      .out_valid (q_ne[g]),
      .out_ready (rd_pop[g]),
      .out_data  (q_data[g])
    );
  end

  logic [$clog2(`MQ_QDEPTH):0] wr_cnt [`MQ_QUEUES];     // words held per queue
  logic [$clog2(`MQ_QDEPTH):0] next_cnt [`MQ_QUEUES];

  // ring-full test repeated here so the flag is exact on the write edge
  function automatic logic g_queue_ready(input int i);
    g_queue_ready = (wr_cnt[i] != `MQ_QDEPTH);
  endfunction

  // full status from the occupancy counters
  always_comb begin
    for (int i = 0; i < `MQ_QUEUES; i++) begin
      q_full[i] = !g_queue_ready(i);
    end
  end

  // occupancy tracking for every queue, selected or not
  always_comb begin
    for (int i = 0; i < `MQ_QUEUES; i++) begin
      next_cnt[i] = wr_cnt[i] + wr_fire[i] - rd_pop[i];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `MQ_QUEUES; i++) begin
        wr_cnt[i] <= '0;
      end
    end else begin
      wr_cnt <= next_cnt;
    end
  end

  // ---------------- read selection and pipeline ----------------
  mq_pkg::sel_phase_type  rph;                    // read switch phase
  mq_pkg::sel_phase_type  next_rph;
  mq_pkg::rsrc_type       rsrc;                   // queue feeding pipeline
  mq_pkg::rsrc_type       next_rsrc;
  mq_pkg::rsrc_type       rnew;                   // pending new source
  mq_pkg::rsrc_type       next_rnew;
  mq_pkg::rsrc_type       src_now;                // source of this cycle
  mq_pkg::stage_type      pipe;                   // inner pipeline stage
  mq_pkg::stage_type      next_pipe;
  mq_pkg::stage_type      outr;                   // output register
  mq_pkg::stage_type      next_outr;
  logic                   q_avail;
  logic                   move;
  logic                   take;

  // read selection, forced advance and fall-through
  always_comb begin
    next_rph  = rph;
    next_rsrc = rsrc;
    next_rnew = rnew;
    next_pipe = pipe;
    next_outr = outr;
    if (rd_port.read_address_enable) begin
      // null bit or a foreign identity makes a permanently empty source
      next_rnew.null_q = rd_port.read_queue_address[`MQ_NULL_BIT]
                         || !id_match(rd_port.read_queue_address[`MQ_RID_HI:`MQ_RID_LO], dev_id); // see [R17] see [R18]
      next_rnew.idx    = rd_port.read_queue_address[`MQ_QIDX_HI:0]; // see [R10]
      next_rph         = mq_pkg::PH_FIRST;
    end else begin
      case (rph)
        mq_pkg::PH_FIRST: begin
          next_rsrc = rnew;
          next_rph  = mq_pkg::PH_SECOND;
        end
        mq_pkg::PH_SECOND: begin
          next_rph = mq_pkg::PH_IDLE;
        end
        default: begin
          next_rph = mq_pkg::PH_IDLE;
        end
      endcase
    end
    // on the edge after selection the pipeline fetches from the new queue
    src_now = (rph == mq_pkg::PH_FIRST) ? rnew : rsrc; // see [R14]
    q_avail = !src_now.null_q && q_ne[src_now.idx]; // see [R19] see [R20]
    // switch edges advance regardless of read enable
    move    = (rph != mq_pkg::PH_IDLE) || !rd_port.read_enable_n || !outr.valid; // see [R13] see [R21]
    take    = !pipe.valid || move;
    if (move) begin
      next_outr.valid = pipe.valid; // see [R22] see [R16]
      if (pipe.valid) begin
        next_outr.data = pipe.data; // see [R12]
      end
    end
    if (take) begin
      next_pipe.valid = q_avail;
      if (q_avail) begin
        next_pipe.data = q_data[src_now.idx];
      end
    end
    for (int i = 0; i < `MQ_QUEUES; i++) begin
      rd_pop[i] = take && q_avail && (src_now.idx == i[`MQ_QIDX_W-1:0]);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rph  <= mq_pkg::PH_IDLE;
      rsrc <= `MQ_RSRC_RST;
      rnew <= `MQ_RSRC_RST;
      pipe <= '0;
      outr <= '0;
    end else begin
      rph  <= next_rph;
      rsrc <= next_rsrc;
      rnew <= next_rnew;
      pipe <= next_pipe;
      outr <= next_outr;
    end
  end

  // output pins; enable only gates the drivers
  assign read_data      = outr.data;
  assign read_data_oe_n = output_enable_n; // see [R15]
  assign output_valid_n = !outr.valid;

  // ---------------- checks ----------------
  wsel_latch_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [R01]
    wr_port.write_address_enable |=> (wph == mq_pkg::PH_FIRST)
      && (wnew == $past(wr_port.write_queue_address[`MQ_QIDX_HI:0])))
    else $error("write selection not captured");

  wsel_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [R02]
    (wph == mq_pkg::PH_IDLE && !wr_port.write_address_enable) |=> $stable(wq) && $stable(wdev))
    else $error("write target changed without selection");

  flag_switch_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [R05]
    (wr_port.write_address_enable ##1 !wr_port.write_address_enable)
      |=> (wq == $past(wr_port.write_queue_address[`MQ_QIDX_HI:0], 2)) && (queue_full_n == !q_full[wq]))
    else $error("full flag not on new queue");

  old_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [R07]
    (wph == mq_pkg::PH_FIRST && !wr_port.write_enable_n && wdev && !q_full[wq]) |-> wr_fire[wq])
    else $error("transition write lost from previous queue");

  full_block_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [R08]
    !(|(wr_fire & q_full)))
    else $error("write into full queue");

  new_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [R06]
    (wr_port.write_address_enable && w_id_ok ##1 !wr_port.write_address_enable
      ##1 (!wr_port.write_enable_n && !q_full[wq] && !wr_port.write_address_enable))
      |-> wr_fire[wq] && (wq == $past(wr_port.write_queue_address[`MQ_QIDX_HI:0], 2)))
    else $error("new queue not written on second edge");

  forced_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [R13]
    (rph == mq_pkg::PH_FIRST && pipe.valid) |=> outr.valid && (outr.data == $past(pipe.data)))
    else $error("previous queue word not advanced");

  new_word_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [R12]
    (rph == mq_pkg::PH_FIRST && !rnew.null_q && q_ne[rnew.idx]) |=> ##1 !output_valid_n)
    else $error("new queue word late");

  null_drain_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [R19]
    (rph == mq_pkg::PH_FIRST && rnew.null_q) |=> ##1 output_valid_n && $stable(read_data))
    else $error("null queue left output valid");

endmodule // multi_queue_port_select

// >>> testbench/ctrl_port_model.sv
`timescale 1ns/1ps
`include "mq_defines.svh"
// controller model: drives both ports, one request per clock
module ctrl_port_model (
  // clock and reset
  input  wire logic           clk_sys,
  input  wire logic           rst_n,
  // port requests
  output mq_pkg::wr_port_type wr_port,
  output mq_pkg::rd_port_type rd_port
);
  int wgap = 2; // cycles since the last write selection
  int rgap = 2; // cycles since the last read selection

  // idle requests at time zero
  initial begin
    wr_port = '0;
    rd_port = '0;
    wr_port.write_enable_n = 1'b1;
    rd_port.read_enable_n = 1'b1;
  end

  // one cycle of requests, changed after the falling edge and held to the next one
  task automatic drive(input logic wa, input logic [6:0] waddr, input logic wen_n, input logic [17:0] wd,
                       input logic ra, input logic [7:0] raddr, input logic ren_n);
    @(negedge clk_sys);
    wgap++;
    rgap++;
    // nothing is selected while reset is held
    if (!rst_n) begin
      wa = 1'b0;
      ra = 1'b0;
    end
    // a selection too soon after the last one is held back
    if (wa && wgap < 2) wa = 1'b0;
    if (ra && rgap < 2) ra = 1'b0;
    if (wa) wgap = 0;
    if (ra) rgap = 0;
    // unused lines carry the inverse of their last value
    wr_port.write_address_enable <= wa;
    wr_port.write_queue_address  <= wa ? waddr : ~wr_port.write_queue_address;
    wr_port.write_enable_n       <= wen_n;
    wr_port.write_data           <= wen_n ? ~wr_port.write_data : wd;
    rd_port.read_address_enable  <= ra;
    rd_port.read_queue_address   <= ra ? raddr : ~rd_port.read_queue_address;
    rd_port.read_enable_n        <= ren_n;
  endtask
endmodule // ctrl_port_model

// >>> testbench/tb_multi_queue_port_select.sv
`timescale 1ns/1ps
`include "mq_defines.svh"
// bench: random words through the controller model, compared against a queue model
module tb_multi_queue_port_select;
  logic                clk_sys = 1'b0;         // system clock
  logic                rst_n = 1'b0;           // reset, active low
  logic [2:0]          id = 3'h0;              // identity straps
  logic                output_enable_n = 1'b0; // data pin enable
  logic                ren_n = 1'b1;           // read enable of the read phase
  mq_pkg::wr_port_type wr_port;                // write requests
  mq_pkg::rd_port_type rd_port;                // read requests
  logic                queue_full_n;           // full flag of write target
  logic                queue_full_oe_n;        // full flag drive enable
  logic                read_data_oe_n;         // data pin drive enable
  logic                output_valid_n;         // output word invalid when high
  logic [17:0]         read_data;              // output register
  int                  err_count = 0;          // mismatches
  int                  tests_run = 0;          // comparisons
  logic [31:0]         seed = 32'h544372D3;    // random state
  logic [17:0]         qm [16][16];            // queue contents model, one ring per queue
  int                  qh [16];                // ring head per queue
  int                  qc [16];                // words held per queue
  logic [4:0]          w_old = 5'h00;          // previous write target, bit 4 own device
  logic [4:0]          w_new = 5'h00;          // new write target
  int                  w_left = 0;             // transition cycles left
  logic [4:0]          r_src = 5'h00;          // read source, bit 4 real queue
  logic [4:0]          r_new = 5'h00;          // pending read source
  int                  r_ph = 0;               // read switch cycle, 0 when idle
  logic                pv = 1'b0;              // pipe stage valid
  logic                ov = 1'b0;              // output register valid
  logic [17:0]         pd = 18'h00000;         // pipe stage word
  logic [17:0]         od = 18'h00000;         // output register word

  // clock, 20 ns period
  always #10 clk_sys = ~clk_sys;

  ctrl_port_model ctrl_port_model_i (.clk_sys(clk_sys), .rst_n(rst_n), .wr_port(wr_port), .rd_port(rd_port));

  multi_queue_port_select multi_queue_port_select_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .device_identity_bit0(id[0]), .device_identity_bit1(id[1]),
    .device_identity_bit2(id[2]), .wr_port(wr_port), .queue_full_n(queue_full_n),
    .queue_full_oe_n(queue_full_oe_n), .rd_port(rd_port), .output_enable_n(output_enable_n),
    .read_data(read_data), .read_data_oe_n(read_data_oe_n), .output_valid_n(output_valid_n));

  // next random word
  function automatic logic [17:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[17:0];
  endfunction

  // compare one value, report a difference
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one clock of both ports, model update at the edge, checks once settled
  task automatic cyc(input logic wa, input logic [6:0] waddr, input logic wen_n, input logic [17:0] wd,
                     input logic ra = 1'b0, input logic [7:0] raddr = 8'h00);
    logic [4:0] dest;
    logic [4:0] tgt;
    logic [4:0] src;
    logic       wok;
    logic       avail;
    logic       mv;
    logic       tk;
    ctrl_port_model_i.drive(wa, waddr, wen_n, wd, ra, raddr, ren_n);
    output_enable_n <= seed[3];
    @(posedge clk_sys);
    // write side: two transition cycles still go to the old target
    if (wa) begin
      w_old = w_new;
      w_new = {waddr[6:4] == id, waddr[3:0]};
      w_left = 2;
    end
    dest = (w_left > 0) ? w_old : w_new;
    if (w_left > 0) w_left--;
    tgt = (w_left > 0) ? w_old : w_new;
    // read side: both switch cycles advance, otherwise read enable or an empty output does
    src = (r_ph == 1) ? r_new : r_src;
    mv  = (r_ph != 0) || !ren_n || !ov;
    tk  = !pv || mv;
    // occupancy before the edge decides both sides
    wok   = !wen_n && dest[4] && qc[dest[3:0]] < 16;
    avail = tk && src[4] && qc[src[3:0]] > 0;
    if (mv) begin
      ov = pv;
      if (pv) od = pd;
    end
    if (tk) pv = avail;
    if (avail) begin
      pd = qm[src[3:0]][qh[src[3:0]]];
      qh[src[3:0]] = (qh[src[3:0]] + 1) % 16;
      qc[src[3:0]]--;
    end
    if (wok) begin
      qm[dest[3:0]][(qh[dest[3:0]] + qc[dest[3:0]]) % 16] = wd;
      qc[dest[3:0]]++;
    end
    // read selection: new source feeds the pipe from the next edge on
    if (ra) begin
      r_new = {raddr[7:5] == id && !raddr[4], raddr[3:0]};
      r_ph  = 1;
    end else if (r_ph == 1) begin
      r_src = r_new;
      r_ph  = 2;
    end else begin
      r_ph = 0;
    end
    #5;
    check(read_data_oe_n, output_enable_n);
    check(output_valid_n, !ov);
    check(read_data, od);
    if (w_left == 0) check(queue_full_oe_n, !tgt[4]);
    if (tgt[4]) check(queue_full_n, qc[tgt[3:0]] < 16);
  endtask

  // clock with no selection or write; reads follow ren_n
  task automatic idle();
    cyc(1'b0, 7'h00, 1'b1, 18'h00000);
  endtask

  // random word on the write port
  task automatic wrd();
    cyc(1'b0, 7'h00, 1'b0, rnd());
  endtask

  // verdict and end of run
  task automatic final_report();
    if (err_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    for (int i = 0; i < 16; i++) begin
      qh[i] = 0;
      qc[i] = 0;
    end
    id = seed[2:0];
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    check(read_data, 18'h00000);
    check(output_valid_n, 1'b1);
    check(queue_full_n, 1'b1);
    check(queue_full_oe_n, 1'b1);
    rst_n <= 1'b1;
    // write phase: select, stream across switches, fill and overfill
    cyc(1'b1, {id, 4'h2}, 1'b1, 18'h00000);
    idle();
    wrd();
    cyc(1'b1, {id, 4'h5}, 1'b0, rnd());
    repeat (19) wrd();
    cyc(1'b1, {id, 4'h2}, 1'b0, rnd());
    repeat (3) wrd();
    cyc(1'b1, {id ^ 3'h1, 4'h3}, 1'b0, rnd());
    repeat (3) wrd();
    cyc(1'b1, {id, 4'h5}, 1'b0, rnd());
    repeat (3) wrd();
    // read phase: switches, null queue, foreign identity, full drain
    ren_n = 1'b0;
    cyc(1'b0, 7'h00, 1'b1, 18'h00000, 1'b1, {id, 5'h02});
    repeat (3) idle();
    cyc(1'b0, 7'h00, 1'b1, 18'h00000, 1'b1, {id, 5'h1F});
    repeat (3) idle();
    cyc(1'b0, 7'h00, 1'b1, 18'h00000, 1'b1, {id ^ 3'h2, 5'h05});
    repeat (3) idle();
    cyc(1'b0, 7'h00, 1'b1, 18'h00000, 1'b1, {id, 5'h05});
    repeat (19) idle();
    cyc(1'b1, {id, 4'h5}, 1'b1, 18'h00000);
    // read enable off across a switch: forced words arrive, then the output holds
    ren_n = 1'b1;
    cyc(1'b0, 7'h00, 1'b1, 18'h00000, 1'b1, {id, 5'h02});
    repeat (4) idle();
    ren_n = 1'b0;
    repeat (4) idle();
    final_report();
  end

  // watchdog against a hang
  initial begin
    #200000;
    err_count++;
    $display("ERROR %0t: run did not finish", $time);
    final_report();
  end
endmodule // tb_multi_queue_port_select
